// *** design/sec_device.sv ***
// module: device end executing pre-erase and extended-error commands
`timescale 1ns/1ps
`default_nettype none
module sec_device #(
  parameter int ERASE_CYC = sec_pkg::SECTOR_ERASE_CYC, // cycles per sector
  parameter logic [27:0] MAX_LBA = 28'h0FFFFFF, // last user-accessible LBA
  parameter int SECT_PER_TRK = 63, // CHS sectors per track
  parameter int HEADS = 16 // CHS heads
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // async reset, high
  sec_link_if.device link, // task-file link
  input wire logic mediaDefect, // erase of current sector hit media error
  input wire logic deviceFault, // device fault level
  input wire logic geometryInvalid, // no valid CHS translation yet
  output logic eraseActive, // erase engine running
  output logic [27:0] eraseLba // linear address being erased
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ERASE = 3'b010,
    S_DONE = 3'b100
  } sec_dev_state_type;

  typedef struct packed {
    sec_dev_state_type st; // engine state
    logic [7:0] count; // sector count register
    logic [7:0] secNum; // sector number / LBA 7:0
    logic [7:0] cylLo; // cylinder low / LBA 15:8
    logic [7:0] cylHi; // cylinder high / LBA 23:16
    logic [7:0] devHead; // device/head register
    logic [7:0] error; // error register
    logic [7:0] status; // status register
    logic [7:0] extCode; // pending extended error code
    logic [27:0] lba; // current linear address
    logic [8:0] left; // sectors still to erase
    logic [15:0] tick; // cycles into current sector
    logic [7:0] rdData; // registered read data
  } sec_dev_regs_type;

  sec_dev_regs_type s_r, s_nxt; // state and next

  // ==========================================================
  // address helpers
  // CHS to linear: (cyl*HEADS + head)*SPT + sector-1
  function automatic logic [27:0] chsToLba(input logic [15:0] cyl, input logic [3:0] hd,
                                           input logic [7:0] sec);
    logic [31:0] tmp;
    tmp = ({16'h0000, cyl} * 32'(HEADS) + {28'h0000000, hd}) * 32'(SECT_PER_TRK)
          + {24'h000000, sec} - 32'h00000001;
    return tmp[27:0];
  endfunction

  assign eraseActive = (s_r.st == S_ERASE);
  assign eraseLba = s_r.lba;
  assign link.rdData = s_r.rdData;

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [27:0] start;
    logic [27:0] ahead;
    logic isLba;
    start = 28'h0000000;
    ahead = 28'h0000000;
    isLba = 1'b0;
    s_nxt = s_r;
    s_nxt.rdData = 8'h00;
    // register reads; results are only meaningful once busy clears
    if (link.rdStb) begin
      unique case (link.addr)
        sec_pkg::TF_ERROR: s_nxt.rdData = s_r.error;
        sec_pkg::TF_COUNT: s_nxt.rdData = s_r.count;
        sec_pkg::TF_SECNUM: s_nxt.rdData = s_r.secNum;
        sec_pkg::TF_CYLLO: s_nxt.rdData = s_r.cylLo;
        sec_pkg::TF_CYLHI: s_nxt.rdData = s_r.cylHi;
        sec_pkg::TF_DEVHEAD: s_nxt.rdData = s_r.devHead;
        sec_pkg::TF_CMDSTAT: s_nxt.rdData = s_r.status;
        default: s_nxt.rdData = 8'h00;
      endcase
    end
    unique case (s_r.st)
      S_IDLE: begin
        // writes while busy are ignored, so only idle accepts them
        if (link.wrStb) begin
          unique case (link.addr)
            sec_pkg::TF_COUNT: s_nxt.count = link.wrData;
            sec_pkg::TF_SECNUM: s_nxt.secNum = link.wrData;
            sec_pkg::TF_CYLLO: s_nxt.cylLo = link.wrData;
            sec_pkg::TF_CYLHI: s_nxt.cylHi = link.wrData;
            sec_pkg::TF_DEVHEAD: s_nxt.devHead = link.wrData;
            sec_pkg::TF_CMDSTAT: begin
              // new command: clear error state, raise busy
              s_nxt.status = 8'h00;
              s_nxt.status[sec_pkg::ST_OCCUPIED] = 1'b1;
              s_nxt.error = 8'h00;
              s_nxt.st = S_DONE;
              isLba = s_r.devHead[sec_pkg::DH_LBA];
              start = isLba ? {s_r.devHead[3:0], s_r.cylHi, s_r.cylLo, s_r.secNum}
                            : chsToLba({s_r.cylHi, s_r.cylLo}, s_r.devHead[3:0], s_r.secNum);
              if (link.wrData == sec_pkg::CMD_PRE_ERASE) begin
                // no translation means address cannot be found
                if (!isLba && geometryInvalid) begin
                  s_nxt.error[sec_pkg::ER_ADDR_MISSING] = 1'b1;
                  s_nxt.extCode = sec_pkg::XE_ID_NOT_FOUND;
                // out of range reports the missing-address bit with the address-overflow extended code
                end else if (start > MAX_LBA) begin
                  s_nxt.error[sec_pkg::ER_ADDR_MISSING] = 1'b1;
                  s_nxt.extCode = sec_pkg::XE_ADDR_OVERFLOW;
                end else begin
                  // start here, zero count is 256
                  s_nxt.lba = start;
                  s_nxt.left = (s_r.count == 8'h00) ? sec_pkg::FULL_COUNT : {1'b0, s_r.count};
                  s_nxt.tick = 16'h0000;
                  s_nxt.extCode = sec_pkg::XE_NONE;
                  s_nxt.st = S_ERASE;
                end
              end else if (link.wrData == sec_pkg::CMD_EXT_ERROR) begin
                // code from the previous command, then consumed
                s_nxt.error = s_r.extCode;
                s_nxt.extCode = sec_pkg::XE_NONE;
              end else begin
                s_nxt.error[sec_pkg::ER_ABORTED] = 1'b1;
                s_nxt.extCode = sec_pkg::XE_INVALID_CMD;
              end
            end
            default: ;
          endcase
        end
      end
      S_ERASE: begin
        s_nxt.tick = s_r.tick + 16'h0001;
        // media defect stops and reports failing sector
        if (mediaDefect) begin
          s_nxt.error[sec_pkg::ER_DEFECT] = 1'b1;
          s_nxt.extCode = sec_pkg::XE_ERASE_FAIL;
          s_nxt.secNum = s_r.lba[7:0];
          s_nxt.cylLo = s_r.lba[15:8];
          s_nxt.cylHi = s_r.lba[23:16];
          s_nxt.devHead = {s_r.devHead[7:4], s_r.lba[27:24]};
          s_nxt.st = S_DONE;
        end else if (s_r.tick == 16'(ERASE_CYC - 1)) begin
          s_nxt.tick = 16'h0000;
          ahead = s_r.lba + 28'h0000001;
          s_nxt.left = s_r.left - 9'h001;
          if (s_r.left == 9'h001) begin
            s_nxt.st = S_DONE;
          // running past the top reports address missing
          end else if (s_r.lba == MAX_LBA) begin
            s_nxt.error[sec_pkg::ER_ADDR_MISSING] = 1'b1;
            s_nxt.extCode = sec_pkg::XE_ADDR_OVERFLOW;
            s_nxt.st = S_DONE;
          end else begin
            s_nxt.lba = ahead;
          end
        end
      end
      S_DONE: begin
        // clear busy, set ready, fault and error summary
        s_nxt.status = 8'h00;
        s_nxt.status[sec_pkg::ST_READY] = 1'b1;
        s_nxt.status[sec_pkg::ST_FAULT] = deviceFault;
        s_nxt.status[sec_pkg::ST_ERROR] = |s_r.error;
        s_nxt.st = S_IDLE;
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= S_IDLE;
      s_r.status <= sec_pkg::STATUS_RST;
      s_r.count <= 8'h01;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : sec_device
`default_nettype wire

// *** design/sec_host.sv ***
// module: host adapter end issuing commands over the task-file link
`timescale 1ns/1ps
`default_nettype none
module sec_host (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // async reset, high
  sec_link_if.host link, // task-file link
  input wire logic cmdStart, // one-cycle request to issue a command
  input wire logic [7:0] cmdCode, // opcode to issue
  input wire logic [7:0] cmdCount, // sector count
  input wire logic [27:0] cmdAddr, // start address field bits
  input wire logic cmdLba, // address is LBA
  output logic cmdBusy, // command in progress
  output logic cmdDone, // one-cycle completion pulse
  output logic [7:0] resStatus, // final status
  output logic [7:0] resError // final error register
);
  // ==========================================================
  // state
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_WAITRDY = 6'b000010,
    H_LOAD = 6'b000100,
    H_POLL = 6'b001000,
    H_GETERR = 6'b010000,
    H_FIN = 6'b100000
  } sec_host_state_type;

  typedef struct packed {
    sec_host_state_type st; // sequence state
    logic [2:0] step; // register load index
    logic rdPend; // read answer due this cycle
    logic [2:0] gap; // poll spacing
    logic [7:0] code; // latched opcode
    logic [7:0] count; // latched count
    logic [27:0] addr; // latched address
    logic lba; // latched address form
    logic [2:0] addrO; // link address
    logic [7:0] dataO; // link write data
    logic wrO; // link write strobe
    logic rdO; // link read strobe
    logic done; // completion pulse
    logic [7:0] status; // result status
    logic [7:0] error; // result error
  } sec_host_regs_type;

  sec_host_regs_type h_r, h_nxt; // state and next

  assign link.addr = h_r.addrO;
  assign link.wrData = h_r.dataO;
  assign link.wrStb = h_r.wrO;
  assign link.rdStb = h_r.rdO;
  assign cmdBusy = (h_r.st != H_IDLE);
  assign cmdDone = h_r.done;
  assign resStatus = h_r.status;
  assign resError = h_r.error;

  // ==========================================================
  // sequencer
  always_comb begin
    h_nxt = h_r;
    h_nxt.wrO = 1'b0;
    h_nxt.rdO = 1'b0;
    h_nxt.done = 1'b0;
    h_nxt.rdPend = h_r.rdO;
    unique case (h_r.st)
      H_IDLE: if (cmdStart) begin
        h_nxt.code = cmdCode;
        h_nxt.count = cmdCount;
        h_nxt.addr = cmdAddr;
        h_nxt.lba = cmdLba;
        h_nxt.st = H_WAITRDY;
        h_nxt.gap = 3'h0;
      end
      H_WAITRDY: begin
        // issue only when ready and not busy
        if (h_r.rdPend && !link.rdData[sec_pkg::ST_OCCUPIED]
            && link.rdData[sec_pkg::ST_READY]) begin
          h_nxt.st = H_LOAD;
          h_nxt.step = 3'h0;
        end else if (!h_r.rdO && !h_r.rdPend) begin
          h_nxt.addrO = sec_pkg::TF_CMDSTAT;
          h_nxt.rdO = 1'b1;
        end
      end
      H_LOAD: begin
        // parameters first, opcode last; all written for simplicity
        h_nxt.wrO = 1'b1;
        h_nxt.step = h_r.step + 3'h1;
        unique case (h_r.step)
          3'h0: begin h_nxt.addrO = sec_pkg::TF_COUNT; h_nxt.dataO = h_r.count; end
          3'h1: begin h_nxt.addrO = sec_pkg::TF_SECNUM; h_nxt.dataO = h_r.addr[7:0]; end
          3'h2: begin h_nxt.addrO = sec_pkg::TF_CYLLO; h_nxt.dataO = h_r.addr[15:8]; end
          3'h3: begin h_nxt.addrO = sec_pkg::TF_CYLHI; h_nxt.dataO = h_r.addr[23:16]; end
          3'h4: begin
            h_nxt.addrO = sec_pkg::TF_DEVHEAD;
            h_nxt.dataO = {1'b1, h_r.lba, 2'b10, h_r.addr[27:24]};
          end
          default: begin
            h_nxt.addrO = sec_pkg::TF_CMDSTAT;
            h_nxt.dataO = h_r.code;
            h_nxt.st = H_POLL;
            h_nxt.gap = 3'h0;
          end
        endcase
      end
      H_POLL: begin
        // results read only after busy clears
        if (h_r.rdPend && !link.rdData[sec_pkg::ST_OCCUPIED]) begin
          h_nxt.status = link.rdData;
          h_nxt.st = H_GETERR;
        end else if (h_r.gap == 3'(sec_pkg::POLL_GAP_CYC - 1)) begin
          h_nxt.gap = 3'h0;
          h_nxt.addrO = sec_pkg::TF_CMDSTAT;
          h_nxt.rdO = 1'b1;
        end else begin
          h_nxt.gap = h_r.gap + 3'h1;
        end
      end
      H_GETERR: begin
        h_nxt.addrO = sec_pkg::TF_ERROR;
        h_nxt.rdO = 1'b1;
        h_nxt.st = H_FIN;
      end
      H_FIN: if (h_r.rdPend) begin
        h_nxt.error = link.rdData;
        h_nxt.done = 1'b1;
        h_nxt.st = H_IDLE;
      end
      default: h_nxt.st = H_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_r <= '0;
      h_r.st <= H_IDLE;
    end else begin
      h_r <= h_nxt;
    end
  end
endmodule : sec_host
`default_nettype wire

// *** design/sec_link_if.sv ***
// interface: task-file link between host adapter and pre-erase device
`timescale 1ns/1ps
`default_nettype none
interface sec_link_if;
  logic [2:0] addr; // task-file register index
  logic [7:0] wrData; // host write data
  logic wrStb; // one-cycle register write
  logic rdStb; // one-cycle register read
  logic [7:0] rdData; // device read data, cycle after rdStb
  modport device (input addr, input wrData, input wrStb, input rdStb, output rdData);
  modport host (output addr, output wrData, output wrStb, output rdStb, input rdData);
endinterface : sec_link_if
`default_nettype wire

// *** design/sec_pkg.sv ***
// package: task-file layout, command codes, flags and timing for the pre-erase block
package sec_pkg;
  // command codes
  localparam logic [7:0] CMD_PRE_ERASE = 8'hC0;
  localparam logic [7:0] CMD_EXT_ERROR = 8'h03;
  // task-file register indices on the link (3-bit address)
  localparam logic [2:0] TF_DATA = 3'h0;
  localparam logic [2:0] TF_ERROR = 3'h1;
  localparam logic [2:0] TF_COUNT = 3'h2;
  localparam logic [2:0] TF_SECNUM = 3'h3;
  localparam logic [2:0] TF_CYLLO = 3'h4;
  localparam logic [2:0] TF_CYLHI = 3'h5;
  localparam logic [2:0] TF_DEVHEAD = 3'h6;
  localparam logic [2:0] TF_CMDSTAT = 3'h7;
  // status bit positions
  localparam int ST_OCCUPIED = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_ERROR = 0;
  // error bit positions
  localparam int ER_ADDR_MISSING = 4;
  localparam int ER_ABORTED = 2;
  localparam int ER_DEFECT = 0;
  // device/head field
  localparam int DH_LBA = 6;
  localparam int DH_DRIVE_SEL = 4;
  // extended error codes
  localparam logic [7:0] XE_NONE = 8'h00;
  localparam logic [7:0] XE_ERASE_FAIL = 8'h03;
  localparam logic [7:0] XE_ID_NOT_FOUND = 8'h14;
  localparam logic [7:0] XE_INVALID_CMD = 8'h20;
  localparam logic [7:0] XE_ADDR_OVERFLOW = 8'h2F;
  // reset status value and the sector total for a zero count
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [8:0] FULL_COUNT = 9'h100;
  // per-sector erase time and its cycle count at 100 MHz
  localparam int SECTOR_ERASE_NS = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECTOR_ERASE_CYC = (SECTOR_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host poll spacing between status reads
  localparam int POLL_GAP_CYC = 4;
endpackage : sec_pkg

// *** verif/sec_link_asserts.sv ***
// checker: timing and result properties seen on the task-file link
`timescale 1ns/1ps
`default_nettype none
module sec_link_asserts #(
  parameter int ERASE_CYC = sec_pkg::SECTOR_ERASE_CYC // cycles per sector, as the device
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset, high
  input wire logic [2:0] addr, // register index
  input wire logic [7:0] wrData, // host write data
  input wire logic wrStb, // write strobe
  input wire logic rdStb, // read strobe
  input wire logic [7:0] rdData // device read data
);
  // ==========
  // helper state
  logic rdPend; // a read was strobed last cycle
  logic armed; // waiting for first idle status after an opcode
  logic stErr; // error flag of the last idle status read
  logic [2:0] rdAddr; // index on the link last cycle, so of the read strobed then
  logic [7:0] opc; // last opcode written
  logic [7:0] prevOpc; // opcode before it
  logic [7:0] cnt; // last sector count written
  int since; // cycles since the last opcode write
  int span; // expected busy length of an erase
  wire stRd = rdPend && (rdAddr == sec_pkg::TF_CMDSTAT); // status data on the link
  wire erRd = rdPend && (rdAddr == sec_pkg::TF_ERROR); // error data on the link
  wire opcW = wrStb && (addr == sec_pkg::TF_CMDSTAT); // opcode launch
  wire prevBad = (prevOpc != 8'hC0) && (prevOpc != 8'h03); // unsupported code
  wire badOpc = (opc != 8'hC0) && (opc != 8'h03); // unsupported code
  assign span = ((cnt == 8'h00) ? 256 : int'(cnt)) * ERASE_CYC;
  // track commands; reset codes look like a finished request so nothing is expected yet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdPend <= 1'b0;
      rdAddr <= 3'h0;
      armed <= 1'b0;
      stErr <= 1'b0;
      opc <= 8'h03;
      prevOpc <= 8'h03;
      cnt <= 8'h01;
      since <= 0;
    end else begin
      rdPend <= rdStb;
      rdAddr <= addr;
      if (wrStb && (addr == sec_pkg::TF_COUNT)) cnt <= wrData;
      if (since < 100000) since <= since + 1;
      if (stRd && !rdData[sec_pkg::ST_OCCUPIED]) begin
        armed <= 1'b0;
        stErr <= rdData[sec_pkg::ST_ERROR];
      end
      if (opcW) begin
        opc <= wrData;
        prevOpc <= opc;
        since <= 0;
        armed <= 1'b1;
      end
    end
  end
  // ==========
  // sequences and properties
  sequence s_done;
    stRd && !rdData[sec_pkg::ST_OCCUPIED];
  endsequence
  sequence s_err_rd;
    erRd;
  endsequence
  property p_rd_quiet;
    @(posedge clk) disable iff (rst) !rdStb |=> (rdData == 8'h00);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
  property p_done_ready;
    @(posedge clk) disable iff (rst) s_done |-> rdData[sec_pkg::ST_READY];
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("ready missing");
  property p_err_flag;
    @(posedge clk) disable iff (rst) s_err_rd |-> ((rdData != 8'h00) == stErr);
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag mismatch");
  property p_abort_bad;
    @(posedge clk) disable iff (rst) s_err_rd and badOpc |-> rdData[sec_pkg::ER_ABORTED];
  endproperty
  a_abort_bad: assert property (p_abort_bad) else $error("no abort on bad code");
  property p_ext_after_bad;
    @(posedge clk) disable iff (rst)
      s_err_rd and (opc == 8'h03) && prevBad |-> (rdData == 8'h20);
  endproperty
  a_ext_after_bad: assert property (p_ext_after_bad) else $error("wrong extended code");
  property p_ext_clear;
    @(posedge clk) disable iff (rst)
      s_err_rd and (opc == 8'h03) && (prevOpc == 8'h03) |-> (rdData == 8'h00);
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("extended code not cleared");
  property p_erase_no_abort;
    @(posedge clk) disable iff (rst)
      s_err_rd and (opc == 8'hC0) |-> !rdData[sec_pkg::ER_ABORTED];
  endproperty
  a_erase_no_abort: assert property (p_erase_no_abort) else $error("erase aborted");
  // the host polls every few cycles, so the window allows some slack
  property p_erase_span;
    @(posedge clk) disable iff (rst)
      s_done and armed && (opc == 8'hC0) && !rdData[sec_pkg::ST_ERROR]
      |-> (since >= span) && (since <= span + 16);
  endproperty
  a_erase_span: assert property (p_erase_span) else $error("erase length wrong");
endmodule : sec_link_asserts
`default_nettype wire

// *** verif/sector_erase_cmd_exec_tb_top.sv ***
// testbench: host and device joined by the link, commands driven from the host user side, media, fault and geometry inputs straight into the device
`timescale 1ns/1ps
`default_nettype none
module sector_erase_cmd_exec_tb_top;
  logic clk, rst, cmdStart, cmdLba, mediaDefect, deviceFault, geometryInvalid;
  logic cmdBusy, cmdDone, eraseActive;
  logic [7:0] cmdCode, cmdCount, resStatus, resError, n;
  logic [27:0] cmdAddr, eraseLba, firstLba, a;
  int failures, compares, actCyc, i;
  sec_link_if sec_link_if_i ();
  sec_device #(.ERASE_CYC(2), .MAX_LBA(28'h0FFFFFF), .SECT_PER_TRK(63), .HEADS(16)) sec_device_i (
    .clk(clk), .rst(rst), .link(sec_link_if_i), .mediaDefect(mediaDefect),
    .deviceFault(deviceFault), .geometryInvalid(geometryInvalid),
    .eraseActive(eraseActive), .eraseLba(eraseLba));
  sec_host sec_host_i (.clk(clk), .rst(rst), .link(sec_link_if_i), .cmdStart(cmdStart),
    .cmdCode(cmdCode), .cmdCount(cmdCount), .cmdAddr(cmdAddr), .cmdLba(cmdLba),
    .cmdBusy(cmdBusy), .cmdDone(cmdDone), .resStatus(resStatus), .resError(resError));
  sec_link_asserts #(.ERASE_CYC(2)) sec_link_asserts_i (.clk(clk), .rst(rst),
    .addr(sec_link_if_i.addr), .wrData(sec_link_if_i.wrData), .wrStb(sec_link_if_i.wrStb),
    .rdStb(sec_link_if_i.rdStb), .rdData(sec_link_if_i.rdData));
  // ==========
  // clock and erase monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count erase cycles and catch the start address
  always @(posedge clk) begin
    if (eraseActive === 1'b1) begin
      if (actCyc == 0) firstLba = eraseLba;
      actCyc++;
    end
  end
  // ==========
  // helpers
  function automatic logic [27:0] exp_chs(input logic [27:0] f);
    return 28'(({f[23:16], f[15:8]} * 16 + f[27:24]) * 63 + f[7:0] - 1);
  endfunction
  function automatic int exp_span(input logic [7:0] c);
    return ((c == 8'h00) ? 256 : int'(c)) * 2;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one command through the host; a hang is cut off and reported
  task automatic issue(input logic [7:0] c, input logic [7:0] k, input logic [27:0] ad,
                       input logic l);
    int w;
    actCyc = 0;
    @(posedge clk);
    cmdStart <= 1'b1;
    cmdCode <= c;
    cmdCount <= k;
    cmdAddr <= ad;
    cmdLba <= l;
    @(posedge clk);
    cmdStart <= 1'b0;
    #1;
    chk(32'(cmdBusy), 32'h1);
    w = 0;
    while (cmdDone !== 1'b1 && w < 3000) begin
      @(posedge clk);
      #1;
      w++;
    end
    // a done pulse on the very last try still counts as finished
    if (cmdDone !== 1'b1) begin
      failures++;
      wrap_up();
    end
    @(posedge clk);
    #1;
    chk(32'(cmdBusy), 32'h0);
  endtask
  // failing command, then the extended code request right after it
  task automatic err_case(input logic [7:0] c, input logic [7:0] k, input logic [27:0] ad,
                          input logic l, input logic m, input logic f, input logic g,
                          input logic [7:0] es, input logic [7:0] ee, input logic [7:0] ex);
    mediaDefect <= m;
    deviceFault <= f;
    geometryInvalid <= g;
    issue(c, k, ad, l);
    chk(32'(resStatus), 32'(es));
    chk(32'(resError), 32'(ee));
    // defect on the first sector: address registers must point at the start
    if (m) chk(32'({sec_device_i.s_r.devHead[3:0], sec_device_i.s_r.cylHi,
                    sec_device_i.s_r.cylLo, sec_device_i.s_r.secNum}), 32'(ad));
    mediaDefect <= 1'b0;
    deviceFault <= 1'b0;
    geometryInvalid <= 1'b0;
    issue(8'h03, 8'h00, 28'h0, 1'b1);
    chk(32'(resStatus), 32'h41);
    chk(32'(resError), 32'(ex));
  endtask
  // ==========
  // main sequence
  initial begin
    rst = 1'b1;
    {cmdStart, cmdLba, mediaDefect, deviceFault, geometryInvalid} = 5'h00;
    cmdCode = 8'h00;
    cmdCount = 8'h00;
    cmdAddr = 28'h0;
    failures = 0;
    compares = 0;
    actCyc = 0;
    void'($urandom(93));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // erases stand in for pre-write conditioning
    // random erases; the first uses count zero, the 256-sector corner
    for (i = 0; i < 5; i++) begin
      a = 28'($urandom_range(32'h0FFFE00));
      n = (i == 0) ? 8'h00 : 8'($urandom_range(1, 16));
      issue(8'hC0, n, a, 1'b1);
      chk(32'(resStatus), 32'h40);
      chk(32'(resError), 32'h00);
      chk(32'(firstLba), 32'(a));
      chk(32'(actCyc), 32'(exp_span(n)));
    end
    // start given as cylinder, head and sector
    issue(8'hC0, 8'h03, {4'h3, 8'h00, 8'h05, 8'h07}, 1'b0);
    chk(32'(firstLba), 32'(exp_chs({4'h3, 8'h00, 8'h05, 8'h07})));
    chk(32'(actCyc), 32'(exp_span(8'h03)));
    n = 8'h40 | 8'($urandom_range(0, 63));
    err_case(n, 8'h01, 28'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h41, 8'h04, 8'h20);
    err_case(n, 8'h01, 28'h0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h61, 8'h04, 8'h20);
    err_case(8'hC0, 8'h04, a, 1'b1, 1'b1, 1'b0, 1'b0, 8'h41, 8'h01, 8'h03);
    err_case(8'hC0, 8'h01, 28'hFFFFFFF, 1'b1, 1'b0, 1'b0, 1'b0, 8'h41, 8'h10, 8'h2F);
    err_case(8'hC0, 8'h01, 28'h0000101, 1'b0, 1'b0, 1'b0, 1'b1, 8'h41, 8'h10, 8'h14);
    // a second request finds the code already cleared
    issue(8'h03, 8'h00, 28'h0, 1'b1);
    chk(32'(resStatus), 32'h40);
    chk(32'(resError), 32'h00);
    wrap_up();
  end
endmodule : sector_erase_cmd_exec_tb_top
`default_nettype wire
